//--- src/dtmr_timers.v
// dual up-counting timers with prescalers, gating, overflow flags and register port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "dtmr_map.vh"

// Contract
// R01 - timer a modes: 13, 16, reload, split
// R02 - timer b modes 00-10; code 11 reserved
// R03 - 13-bit: overflow 0xff1f to 0x0000, flag
// R04 - 16-bit: overflow 0xffff to 0x0000, flag
// R05 - reload: low wraps, flag, high copied in
// R06 - split low byte: a clock, a run, a flag
// R07 - split high byte: cpu/12, b run, b flag
// R08 - split mode: timer b counts without flag
// R09 - timer b gate pauses on irq-one pin
// R10 - timer a gate pin; split: low only
// R11 - clock type: cpu/12 or divided external source
// R12 - a source select: main or low-speed oscillator
// R13 - rate field: 000 /128 through 111 /1
// R14 - overflow flag set; service or write-0 clears
// R15 - irq enable bits 1 and 3 request interrupts
// R16 - stop mode: oscillator-clocked a counts, wakes
// R17 - count bytes reset 0x00, software read/write
// R18 - run bit clear freezes counter value; in split mode timer b ignores its run bit
module dtmr_timers #(
    parameter CPU_DIV = `DTMR_CPU_DIV
) (
    input  wire       clock,
    input  wire       arst_n,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    input  wire       osc_tick,
    input  wire       losc_tick,
    input  wire       tmr_a_gate_pin,
    input  wire       ext_irq_one_pin,
    input  wire       stop_mode,
    input  wire       tmr_a_irq_ack,
    input  wire       tmr_b_irq_ack,
    output wire       tmr_a_irq_req,
    output wire       tmr_b_irq_req,
    output wire       wake_request,
    output wire       irq
);

    // last value of the cpu/12 divider, cut to the counter's width on purpose
    localparam integer CPU_LAST = CPU_DIV - 1;
    localparam [3:0]   CPU_TERM = CPU_LAST[3:0];

    // software-visible state
    reg  [7:0] tmr_a_low_byte;
    reg  [7:0] tmr_a_high_byte;
    reg  [7:0] tmr_b_low_byte;
    reg  [7:0] tmr_b_high_byte;
    reg        tmr_a_overflow_flag;
    reg        tmr_b_overflow_flag;
    reg        tmr_a_run;
    reg        tmr_b_run;
    reg  [3:0] ctrl_low_bits;
    reg  [7:0] timer_mode_select;
    reg  [7:0] interrupt_enable_zero;
    reg  [7:0] timer_clock_divider;
    reg        stop_wake_enable;
    reg  [1:0] evt_status;
    reg  [1:0] evt_mask;

    // prescaler state
    reg  [3:0] cpu_cnt;
    reg  [6:0] a_pre_cnt;
    reg  [6:0] b_pre_cnt;

    // combinational next values
    reg  [7:0] next_a_low;
    reg  [7:0] next_a_high;
    reg  [7:0] next_b_low;
    reg  [7:0] next_b_high;
    reg        a_ovf;
    reg        b_ovf;
    reg [16:0] a_res;
    reg [16:0] b_res;
    reg  [8:0] split_hi_sum;

    // field views
    wire [1:0] tmr_a_mode_field     = timer_mode_select[`DTMR_A_MODE_HI:`DTMR_A_MODE_LO];
    wire [1:0] tmr_b_mode_field     = timer_mode_select[`DTMR_B_MODE_HI:`DTMR_B_MODE_LO];
    wire       tmr_a_clock_type     = timer_mode_select[`DTMR_A_CT_BIT];
    wire       tmr_b_clock_type     = timer_mode_select[`DTMR_B_CT_BIT];
    wire       tmr_a_gate_enable    = timer_mode_select[`DTMR_A_GATE_BIT];
    wire       tmr_b_gate_enable    = timer_mode_select[`DTMR_B_GATE_BIT];
    wire       tmr_a_ext_source_sel = timer_clock_divider[`DTMR_A_EXT_SEL_BIT];
    wire [2:0] tmr_a_rate_field     = timer_clock_divider[`DTMR_A_RATE_HI:`DTMR_A_RATE_LO];
    wire [2:0] tmr_b_rate_field     = timer_clock_divider[`DTMR_B_RATE_HI:`DTMR_B_RATE_LO];
    wire       global_irq_enable    = interrupt_enable_zero[`DTMR_GLOBAL_EN_BIT];
    wire       tmr_a_irq_enable     = interrupt_enable_zero[`DTMR_A_IRQ_EN_BIT];
    wire       tmr_b_irq_enable     = interrupt_enable_zero[`DTMR_B_IRQ_EN_BIT];
    wire       a_split              = (tmr_a_mode_field == `DTMR_MODE_SPLIT);

    // terminal count of a prescaler: rate 000 divides by 128, 111 by 1
    function [6:0] rate_term;
        input [2:0] rate;
        begin
            rate_term = `DTMR_PRESCALE_MAX >> rate; // R13
        end
    endfunction

    // one count step of a timer in modes 0 to 2; returns {overflow, high, low}
    function [16:0] tmr_step;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        reg   [13:0] s13;
        reg   [16:0] s16;
        reg   [8:0]  s8;
        begin
            s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            s16 = {1'b0, hi, lo} + 17'h00001;
            s8  = {1'b0, lo} + 9'h001;
            case (mode)
                // upper three low bits are left alone in 13-bit mode
                `DTMR_MODE_13BIT: tmr_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // R03
                `DTMR_MODE_16BIT: tmr_step = s16; // R04
                `DTMR_MODE_RELOAD: begin
                    if (s8[8]) begin
                        tmr_step = {1'b1, hi, hi}; // R05
                    end else begin
                        tmr_step = {1'b0, hi, s8[7:0]};
                    end
                end
                default: tmr_step = {1'b0, hi, lo};
            endcase
        end
    endfunction

    // register decode
    wire wr_ctrl   = reg_write && (reg_addr == `DTMR_OFS_CTRL_FLAGS);
    wire wr_mode   = reg_write && (reg_addr == `DTMR_OFS_MODE_SEL);
    wire wr_a_low  = reg_write && (reg_addr == `DTMR_OFS_A_LOW);
    wire wr_b_low  = reg_write && (reg_addr == `DTMR_OFS_B_LOW);
    wire wr_a_high = reg_write && (reg_addr == `DTMR_OFS_A_HIGH);
    wire wr_b_high = reg_write && (reg_addr == `DTMR_OFS_B_HIGH);
    wire wr_ien    = reg_write && (reg_addr == `DTMR_OFS_IRQ_EN);
    wire wr_div    = reg_write && (reg_addr == `DTMR_OFS_CLK_DIV);
    wire wr_wake   = reg_write && (reg_addr == `DTMR_OFS_WAKE_CTRL);
    wire wr_status = reg_write && (reg_addr == `DTMR_OFS_EVT_STATUS);
    wire wr_mask   = reg_write && (reg_addr == `DTMR_OFS_EVT_MASK);

    // core clock / 12 tick; the core clock is gone in stop mode
    wire cpu_tick = (cpu_cnt == CPU_TERM) && !stop_mode;

    // external sources and prescaled ticks
    wire a_src_tick = tmr_a_ext_source_sel ? losc_tick : osc_tick; // R12
    wire a_pre_tick = a_src_tick && (a_pre_cnt >= rate_term(tmr_a_rate_field));
    wire b_pre_tick = osc_tick && (b_pre_cnt >= rate_term(tmr_b_rate_field));

    // selected timer clocks
    wire a_clk_tick = tmr_a_clock_type ? a_pre_tick : cpu_tick; // R11
    wire b_clk_tick = tmr_b_clock_type ? b_pre_tick : cpu_tick; // R11

    // only an oscillator-clocked timer a with wake enabled runs in stop mode
    wire a_stop_ok = !stop_mode || (tmr_a_clock_type && stop_wake_enable); // R16

    // gating: a gate pin pauses the clock while it is low
    wire a_gate_ok = !tmr_a_gate_enable || tmr_a_gate_pin; // R10
    wire b_gate_ok = !tmr_b_gate_enable || ext_irq_one_pin; // R09

    // count enables; run bit low freezes the counter
    wire a_count = tmr_a_run && a_gate_ok && a_clk_tick && a_stop_ok; // R18
    wire b_count_run = tmr_b_run && b_gate_ok && b_clk_tick && !stop_mode; // R18
    // in split mode timer b free-runs on its own clock and gate
    wire b_count_free = b_gate_ok && b_clk_tick && !stop_mode; // R08
    wire b_count = a_split ? b_count_free : b_count_run;
    wire split_hi_count = a_split && tmr_b_run && cpu_tick; // R07

    // prescaler counters run on every source tick
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cpu_cnt   <= 4'h0;
            a_pre_cnt <= 7'h00;
            b_pre_cnt <= 7'h00;
        end else begin
            if (cpu_cnt >= CPU_TERM) begin
                cpu_cnt <= 4'h0;
            end else begin
                cpu_cnt <= cpu_cnt + 4'h1;
            end
            // >= compare recovers if the rate shrinks mid-count
            if (a_src_tick) begin
                if (a_pre_tick) begin
                    a_pre_cnt <= 7'h00;
                end else begin
                    a_pre_cnt <= a_pre_cnt + 7'h01;
                end
            end
            if (osc_tick) begin
                if (b_pre_tick) begin
                    b_pre_cnt <= 7'h00;
                end else begin
                    b_pre_cnt <= b_pre_cnt + 7'h01;
                end
            end
        end
    end

    // counter next values; a software write to a byte wins over counting
    always @* begin
        a_res        = tmr_step(tmr_a_mode_field, tmr_a_high_byte, tmr_a_low_byte);
        b_res        = tmr_step(tmr_b_mode_field, tmr_b_high_byte, tmr_b_low_byte);
        split_hi_sum = {1'b0, tmr_a_high_byte} + 9'h001;
        next_a_low   = tmr_a_low_byte;
        next_a_high  = tmr_a_high_byte;
        next_b_low   = tmr_b_low_byte;
        next_b_high  = tmr_b_high_byte;
        a_ovf        = 1'b0;
        b_ovf        = 1'b0;
        if (a_split) begin
            // low byte is timer a, high byte borrows timer b's run and flag
            if (a_count) begin
                next_a_low = tmr_a_low_byte + 8'h01; // R06
                a_ovf      = (tmr_a_low_byte == 8'hff); // R06
            end
            if (split_hi_count) begin
                next_a_high = split_hi_sum[7:0]; // R07
                b_ovf       = split_hi_sum[8]; // R07
            end
        end else if (a_count) begin
            next_a_high = a_res[15:8]; // R01
            next_a_low  = a_res[7:0]; // R01
            a_ovf       = a_res[16];
        end
        // reserved code 11 holds timer b still
        if (b_count && (tmr_b_mode_field != `DTMR_MODE_SPLIT)) begin
            next_b_high = b_res[15:8]; // R02
            next_b_low  = b_res[7:0]; // R02
            if (!a_split) begin
                b_ovf = b_res[16]; // R08
            end
        end
        if (wr_a_low) begin
            next_a_low = reg_wdata; // R17
        end
        if (wr_a_high) begin
            next_a_high = reg_wdata; // R17
        end
        if (wr_b_low) begin
            next_b_low = reg_wdata; // R17
        end
        if (wr_b_high) begin
            next_b_high = reg_wdata; // R17
        end
    end

    // counter bytes
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tmr_a_low_byte  <= `DTMR_RST_BYTE; // R17
            tmr_a_high_byte <= `DTMR_RST_BYTE;
            tmr_b_low_byte  <= `DTMR_RST_BYTE;
            tmr_b_high_byte <= `DTMR_RST_BYTE;
        end else begin
            tmr_a_low_byte  <= next_a_low;
            tmr_a_high_byte <= next_a_high;
            tmr_b_low_byte  <= next_b_low;
            tmr_b_high_byte <= next_b_high;
        end
    end

    // overflow flags: an overflow in the cycle of a clear still sets the flag
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tmr_a_overflow_flag <= 1'b0;
            tmr_b_overflow_flag <= 1'b0;
        end else begin
            if (a_ovf) begin
                tmr_a_overflow_flag <= 1'b1; // R14
            end else if (wr_ctrl) begin
                tmr_a_overflow_flag <= reg_wdata[`DTMR_A_OVF_BIT]; // R14
            end else if (tmr_a_irq_ack) begin
                tmr_a_overflow_flag <= 1'b0; // R14
            end
            if (b_ovf) begin
                tmr_b_overflow_flag <= 1'b1; // R14
            end else if (wr_ctrl) begin
                tmr_b_overflow_flag <= reg_wdata[`DTMR_B_OVF_BIT]; // R14
            end else if (tmr_b_irq_ack) begin
                tmr_b_overflow_flag <= 1'b0; // R14
            end
        end
    end

    // control and configuration registers
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tmr_a_run             <= 1'b0;
            tmr_b_run             <= 1'b0;
            ctrl_low_bits         <= 4'h0;
            timer_mode_select     <= `DTMR_RST_BYTE;
            interrupt_enable_zero <= `DTMR_RST_BYTE;
            timer_clock_divider   <= `DTMR_RST_BYTE;
            stop_wake_enable      <= 1'b0;
            evt_mask              <= `DTMR_RST_EVT;
        end else begin
            if (wr_ctrl) begin
                tmr_a_run     <= reg_wdata[`DTMR_A_RUN_BIT];
                tmr_b_run     <= reg_wdata[`DTMR_B_RUN_BIT];
                ctrl_low_bits <= reg_wdata[3:0];
            end
            if (wr_mode) begin
                timer_mode_select <= reg_wdata;
            end
            if (wr_ien) begin
                interrupt_enable_zero <= reg_wdata;
            end
            if (wr_div) begin
                // reserved bit is held at zero
                timer_clock_divider <= reg_wdata & 8'hf7;
            end
            if (wr_wake) begin
                stop_wake_enable <= reg_wdata[`DTMR_WAKE_EN_BIT];
            end
            if (wr_mask) begin
                evt_mask <= reg_wdata[1:0];
            end
        end
    end

    // sticky event status, write one to clear; a new event wins over the clear
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            evt_status <= `DTMR_RST_EVT;
        end else begin
            evt_status <= {b_ovf, a_ovf} | (evt_status & ~(wr_status ? reg_wdata[1:0] : 2'b00));
        end
    end

    // read data, one cycle after the strobe; unmapped offsets read zero
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `DTMR_OFS_CTRL_FLAGS: reg_rdata <= {tmr_b_overflow_flag, tmr_b_run,
                                                    tmr_a_overflow_flag, tmr_a_run,
                                                    ctrl_low_bits};
                `DTMR_OFS_MODE_SEL:   reg_rdata <= timer_mode_select;
                `DTMR_OFS_A_LOW:      reg_rdata <= tmr_a_low_byte; // R17
                `DTMR_OFS_B_LOW:      reg_rdata <= tmr_b_low_byte;
                `DTMR_OFS_A_HIGH:     reg_rdata <= tmr_a_high_byte;
                `DTMR_OFS_B_HIGH:     reg_rdata <= tmr_b_high_byte;
                `DTMR_OFS_IRQ_EN:     reg_rdata <= interrupt_enable_zero;
                `DTMR_OFS_CLK_DIV:    reg_rdata <= timer_clock_divider;
                `DTMR_OFS_WAKE_CTRL:  reg_rdata <= {7'h00, stop_wake_enable};
                `DTMR_OFS_EVT_STATUS: reg_rdata <= {6'h00, evt_status};
                `DTMR_OFS_EVT_MASK:   reg_rdata <= {6'h00, evt_mask};
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // interrupt requests toward the controller; flags stay pollable when disabled
    assign tmr_a_irq_req = tmr_a_overflow_flag && tmr_a_irq_enable && global_irq_enable; // R15
    assign tmr_b_irq_req = tmr_b_overflow_flag && tmr_b_irq_enable && global_irq_enable; // R15

    // wake only from an oscillator-clocked timer a request during stop
    assign wake_request = stop_mode && stop_wake_enable && tmr_a_clock_type
                          && tmr_a_irq_req; // R16

    // block-level interrupt from the masked sticky status
    assign irq = |(evt_status & evt_mask);

endmodule

//--- src/dtmr_map.vh
// register map, field positions, reset values and timing counts of the dual timer block
`ifndef DTMR_MAP_VH
`define DTMR_MAP_VH

// register offsets
`define DTMR_OFS_CTRL_FLAGS   8'h88
`define DTMR_OFS_MODE_SEL     8'h89
`define DTMR_OFS_A_LOW        8'h8a
`define DTMR_OFS_B_LOW        8'h8b
`define DTMR_OFS_A_HIGH       8'h8c
`define DTMR_OFS_B_HIGH       8'h8d
`define DTMR_OFS_IRQ_EN       8'ha8
`define DTMR_OFS_CLK_DIV      8'he7
`define DTMR_OFS_WAKE_CTRL    8'he9
`define DTMR_OFS_EVT_STATUS   8'hea
`define DTMR_OFS_EVT_MASK     8'heb

// timer_control_flags fields
`define DTMR_B_OVF_BIT        7
`define DTMR_B_RUN_BIT        6
`define DTMR_A_OVF_BIT        5
`define DTMR_A_RUN_BIT        4

// timer_mode_select fields
`define DTMR_B_GATE_BIT       7
`define DTMR_B_CT_BIT         6
`define DTMR_B_MODE_HI        5
`define DTMR_B_MODE_LO        4
`define DTMR_A_GATE_BIT       3
`define DTMR_A_CT_BIT         2
`define DTMR_A_MODE_HI        1
`define DTMR_A_MODE_LO        0

// interrupt_enable_zero fields
`define DTMR_GLOBAL_EN_BIT    7
`define DTMR_B_IRQ_EN_BIT     3
`define DTMR_A_IRQ_EN_BIT     1

// timer_clock_divider fields
`define DTMR_A_EXT_SEL_BIT    7
`define DTMR_A_RATE_HI        6
`define DTMR_A_RATE_LO        4
`define DTMR_CLK_DIV_RSVD     3
`define DTMR_B_RATE_HI        2
`define DTMR_B_RATE_LO        0

// wake control and event register fields
`define DTMR_WAKE_EN_BIT      0
`define DTMR_EVT_A_BIT        0
`define DTMR_EVT_B_BIT        1

// mode encodings
`define DTMR_MODE_13BIT       2'b00
`define DTMR_MODE_16BIT       2'b01
`define DTMR_MODE_RELOAD      2'b10
`define DTMR_MODE_SPLIT       2'b11

// reset values
`define DTMR_RST_BYTE         8'h00
`define DTMR_RST_EVT          2'b00

// timing counts
`define DTMR_CPU_DIV          12
`define DTMR_PRESCALE_MAX     7'h7f

`endif

//--- verification/dtmr_timers_sva.sv
// port-level properties of the dual timer block
`timescale 1ns/1ps
`include "dtmr_map.vh"
module dtmr_timers_chk #(
    parameter CPU_DIV = 12
) (
    input wire       clock,
    input wire       arst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    input wire       osc_tick,
    input wire       losc_tick,
    input wire       tmr_a_gate_pin,
    input wire       ext_irq_one_pin,
    input wire       stop_mode,
    input wire       tmr_a_irq_ack,
    input wire       tmr_b_irq_ack,
    input wire       tmr_a_irq_req,
    input wire       tmr_b_irq_req,
    input wire       wake_request,
    input wire       irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // mode write, idle cycle, then read back of the same register
    sequence s_mode_wr;
        reg_write && reg_addr == `DTMR_OFS_MODE_SEL;
    endsequence
    sequence s_mode_rd;
        reg_read && reg_addr == `DTMR_OFS_MODE_SEL;
    endsequence

    AST_MODE_BACK: assert property (s_mode_wr ##1 !reg_write ##1 s_mode_rd
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("mode readback wrong");
    AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    AST_UNMAPPED: assert property (reg_read && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RSVD_ZERO: assert property (reg_read && reg_addr == `DTMR_OFS_CLK_DIV
        |=> !reg_rdata[3]) else $error("reserved divider bit set");
    AST_IEN_A_OFF: assert property (reg_write && reg_addr == `DTMR_OFS_IRQ_EN
        && !reg_wdata[1] |=> !tmr_a_irq_req) else $error("timer a request while off");
    AST_IEN_B_OFF: assert property (reg_write && reg_addr == `DTMR_OFS_IRQ_EN
        && !reg_wdata[3] |=> !tmr_b_irq_req) else $error("timer b request while off");
    AST_GLOBAL_OFF: assert property (reg_write && reg_addr == `DTMR_OFS_IRQ_EN
        && !reg_wdata[7] |=> !tmr_a_irq_req && !tmr_b_irq_req) else $error("global off");
    // irq is a gate over registers, so it falls the cycle after the mask write
    AST_MASK_OFF: assert property (reg_write && reg_addr == `DTMR_OFS_EVT_MASK
        && reg_wdata[1:0] == 2'b00 |=> !irq) else $error("irq while masked");
    AST_WAKE_CAUSE: assert property (wake_request |-> stop_mode && tmr_a_irq_req)
        else $error("wake without cause");
    AST_WAKE_ENDS: assert property ($fell(stop_mode) |-> !wake_request)
        else $error("wake outside stop");
endmodule

bind dtmr_timers dtmr_timers_chk #(.CPU_DIV(CPU_DIV)) chk (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .osc_tick(osc_tick), .losc_tick(losc_tick), .tmr_a_gate_pin(tmr_a_gate_pin),
    .ext_irq_one_pin(ext_irq_one_pin), .stop_mode(stop_mode),
    .tmr_a_irq_ack(tmr_a_irq_ack), .tmr_b_irq_ack(tmr_b_irq_ack),
    .tmr_a_irq_req(tmr_a_irq_req), .tmr_b_irq_req(tmr_b_irq_req),
    .wake_request(wake_request), .irq(irq)
);

//--- verification/tb_top.sv
// self-checking bench for the dual timer block
`timescale 1ns/1ps
module tb_top;
    reg         clock, arst_n, reg_write, reg_read, osc_tick, losc_tick;
    reg         tmr_a_gate_pin, ext_irq_one_pin, stop_mode;
    reg         tmr_a_irq_ack, tmr_b_irq_ack;
    reg  [7:0]  reg_addr, reg_wdata, rv;
    wire [7:0]  reg_rdata;
    wire        tmr_a_irq_req, tmr_b_irq_req, wake_request, irq;
    integer     fail_count, comparisons, i, n;
    // offset, setting and expected-value tables, first entry in the low byte
    localparam [87:0] RST_OFS = 88'h8889_8a8b_8c8d_a8e7_e9ea_eb;
    localparam [63:0] RW_OFS  = 64'h8889_8a8b_8c8d_a8e7;
    localparam [39:0] XDV = 40'h60_7070_f070;
    localparam [39:0] XMD = 40'h05_0d0d_0505;
    localparam [4:0]  XGP = 5'b11011;
    localparam [39:0] XEX = 40'h02_0500_0305;

    dtmr_timers #(.CPU_DIV(12)) uut (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .osc_tick(osc_tick), .losc_tick(losc_tick), .tmr_a_gate_pin(tmr_a_gate_pin),
        .ext_irq_one_pin(ext_irq_one_pin), .stop_mode(stop_mode),
        .tmr_a_irq_ack(tmr_a_irq_ack), .tmr_b_irq_ack(tmr_b_irq_ack),
        .tmr_a_irq_req(tmr_a_irq_req), .tmr_b_irq_req(tmr_b_irq_req),
        .wake_request(wake_request), .irq(irq)
    );

    // 125 MHz
    always #4 clock = ~clock;

    task chk(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_write <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_write <= 1'b0;
        end
    endtask

    // read data are valid only in the cycle after the strobe
    task rd(input [7:0] a);
        begin
            @(posedge clock);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge clock);
            reg_read <= 1'b0;
            #1;
            rv = reg_rdata;
        end
    endtask

    task rc(input [7:0] a, input [7:0] e);
        begin
            rd(a);
            chk(rv, e);
        end
    endtask

    // bounded wait: a cpu/12 tick comes well inside 40 cycles
    task wreq(input sel);
        begin
            n = 0;
            while ((sel ? tmr_b_irq_req : tmr_a_irq_req) !== 1'b1 && n < 40) begin
                @(posedge clock);
                #1;
                n = n + 1;
            end
            chk({7'h00, sel ? tmr_b_irq_req : tmr_a_irq_req}, 8'h01);
        end
    endtask

    task ack(input sel);
        begin
            @(posedge clock);
            tmr_a_irq_ack <= !sel;
            tmr_b_irq_ack <= sel;
            @(posedge clock);
            tmr_a_irq_ack <= 1'b0;
            tmr_b_irq_ack <= 1'b0;
            #1;
            chk({6'h00, tmr_b_irq_req, tmr_a_irq_req}, 8'h00);
        end
    endtask

    // one-cycle oscillator pulses with a gap between them
    task tick(input integer cnt, input low_speed);
        repeat (cnt) begin
            @(posedge clock);
            osc_tick  <= !low_speed;
            losc_tick <= low_speed;
            @(posedge clock);
            osc_tick  <= 1'b0;
            losc_tick <= 1'b0;
        end
    endtask

    // timer a from a preset to its first overflow, then frozen
    task ovf(input [7:0] md, input [7:0] hi, input [7:0] lo, input [7:0] eh, input [7:0] el);
        begin
            wr(8'h88, 8'h00);
            wr(8'h8c, hi);
            wr(8'h8a, lo);
            wr(8'h89, md);
            wr(8'ha8, 8'h82);
            wr(8'h88, 8'h10);
            wreq(1'b0);
            wr(8'h88, 8'h20);
            repeat (30) @(posedge clock);
            rc(8'h8c, eh);
            rc(8'h8a, el);
            rc(8'h88, 8'h20);
            ack(1'b0);
            rc(8'h88, 8'h00);
        end
    endtask

    task give_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // a hang is cut short; the run needs about 700 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fail_count = fail_count + 1;
        $display("unexpected at %0t: run timed out", $time);
        give_verdict;
    end

    initial begin
        {clock, arst_n, reg_write, reg_read, osc_tick, losc_tick} = 6'h00;
        {tmr_a_gate_pin, ext_irq_one_pin, stop_mode, tmr_a_irq_ack, tmr_b_irq_ack} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        fail_count = 0;
        comparisons = 0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        for (i = 0; i < 11; i = i + 1)
            rc(RST_OFS[8*i +: 8], 8'h00);
        // divider bit 3 always reads zero
        for (i = 0; i < 8; i = i + 1) begin
            wr(RW_OFS[8*i +: 8], 8'h5a);
            rc(RW_OFS[8*i +: 8], i == 0 ? 8'h52 : 8'h5a);
            wr(RW_OFS[8*i +: 8], 8'h00);
        end
        wr(8'h00, 8'hff);
        rc(8'h00, 8'h00);
        ovf(8'h00, 8'hff, 8'hff, 8'h00, 8'he0);
        ovf(8'h01, 8'hff, 8'hff, 8'h00, 8'h00);
        ovf(8'h02, 8'h37, 8'hff, 8'h37, 8'h37);
        ovf(8'h03, 8'h12, 8'hff, 8'h12, 8'h00);
        // timer b gated by a low pin, then released
        wr(8'h89, 8'h90);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'hff);
        wr(8'ha8, 8'h88);
        wr(8'h88, 8'h40);
        repeat (40) @(posedge clock);
        rc(8'h8b, 8'hff);
        @(posedge clock);
        ext_irq_one_pin <= 1'b1;
        wreq(1'b1);
        ack(1'b1);
        // reserved mode holds timer b
        wr(8'h88, 8'h00);
        wr(8'h8b, 8'h40);
        wr(8'h89, 8'h30);
        wr(8'h88, 8'h40);
        repeat (40) @(posedge clock);
        rc(8'h8b, 8'h40);
        // split: timer b runs flagless, a high byte follows b run
        wr(8'h88, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h8b, 8'hff);
        wr(8'h8d, 8'hff);
        wr(8'h89, 8'h03);
        wr(8'h88, 8'h40);
        repeat (40) @(posedge clock);
        rc(8'h88, 8'h40);
        rd(8'h8c);
        chk({7'h00, rv != 8'h00}, 8'h01);
        rd(8'h8b);
        chk({7'h00, rv != 8'hff}, 8'h01);
        // external sources, rates /1 and /2, source select and gate pin
        wr(8'h88, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'he7, XDV[8*i +: 8]);
            wr(8'h89, XMD[8*i +: 8]);
            tmr_a_gate_pin <= XGP[i];
            wr(8'h8a, 8'h00);
            wr(8'h88, 8'h10);
            tick(5, 1'b0);
            tick(3, 1'b1);
            wr(8'h88, 8'h00);
            rc(8'h8a, XEX[8*i +: 8]);
        end
        // stop mode wake, event mask and write-one clear
        wr(8'he7, 8'h70);
        wr(8'h8c, 8'hff);
        wr(8'h8a, 8'hff);
        wr(8'he9, 8'h01);
        wr(8'ha8, 8'h82);
        stop_mode <= 1'b1;
        wr(8'h88, 8'h10);
        tick(1, 1'b0);
        @(posedge clock);
        #1;
        chk({7'h00, wake_request}, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(8'heb, 8'h01);
        @(posedge clock);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(8'hea, 8'h01);
        @(posedge clock);
        #1;
        chk({7'h00, irq}, 8'h00);
        wr(8'heb, 8'h00);
        stop_mode <= 1'b0;
        @(posedge clock);
        #1;
        chk({7'h00, wake_request}, 8'h00);
        give_verdict;
    end
endmodule
